/* slot_irq_assertions.sv */
`timescale 1ns/1ps
module slot_irq_assertions
(
   input wire logic pclk,
   input wire logic presetn,
   input wire slot_irq_pkg::slot_vec_t normal_out,
   input wire slot_irq_pkg::slot_vec_t normal_oe_n,
   input wire slot_irq_pkg::slot_vec_t fast_out,
   input wire slot_irq_pkg::slot_vec_t fast_oe_n,
   input wire slot_irq_pkg::slot_vec_t card_normal_irq_n,
   input wire logic card_fast_irq_n
);
   import slot_irq_pkg::*;
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   property p_drive_low;
      normal_out == '0 && fast_out == '0;
   endproperty
   a_drive_low: assert property (p_drive_low)
      else $error("card drives a high level");
   property p_normal_line;
      card_normal_irq_n == normal_oe_n;
   endproperty
   a_normal_line: assert property (p_normal_line)
      else $error("slot line differs from card enable");
   property p_fast_pull;
      fast_oe_n != 4'hf |-> !card_fast_irq_n;
   endproperty
   a_fast_pull: assert property (p_fast_pull)
      else $error("fast line not low while driven");
   property p_fast_idle;
      fast_oe_n == 4'hf |-> card_fast_irq_n;
   endproperty
   a_fast_idle: assert property (p_fast_idle)
      else $error("fast line low while released");
   property p_release;
      $rose(presetn) |-> normal_oe_n == 4'hf && fast_oe_n == 4'hf;
   endproperty
   a_release: assert property (p_release)
      else $error("card drives a line out of reset");
   property p_fast_follow;
      $changed(card_fast_irq_n) |-> $changed(fast_oe_n);
   endproperty
   a_fast_follow: assert property (p_fast_follow)
      else $error("fast line moved with no card change");
   property p_normal_follow;
      $changed(card_normal_irq_n) |-> $changed(normal_oe_n);
   endproperty
   a_normal_follow: assert property (p_normal_follow)
      else $error("slot line moved with no card change");
endmodule

/* slot_irq_backplane.sv */
// Our own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module slot_irq_backplane
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [slot_irq_pkg::ADDR_WIDTH-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [slot_irq_pkg::DATA_WIDTH-1:0] pwdata,
   output logic [slot_irq_pkg::DATA_WIDTH-1:0] prdata,
   output logic pready,
   output logic pslverr,
   slot_irq_bus.backplane bus,
   output logic host_normal_irq_n,
   output logic host_fast_irq_n,
   output logic [slot_irq_pkg::REG_WIDTH-1:0] host_irq_status_b,
   output logic [slot_irq_pkg::REG_WIDTH-1:0] host_fiq_status
);
   import slot_irq_pkg::*;

   function automatic logic reg_hit
   (
      input logic [ADDR_WIDTH-1:0] addr,
      input logic [ADDR_WIDTH-1:0] offset
   );
      reg_hit = (addr == offset);
   endfunction

   function automatic logic any_set
   (
      input slot_vec_t vec
   );
      any_set = |vec;
   endfunction

   slot_vec_t slot_req_n_sync;
   logic fast_n_sync;
   slot_vec_t slot_req;
   slot_vec_t mask_reg;
   reg_byte_t status_next;
   apb_phase_t phase_reg;
   logic setup_cycle;
   logic write_commit;
   logic addr_known;

   // pins from the slots are asynchronous to pclk
   slot_irq_sync #(
      .WIDTH(SLOT_COUNT)
   ) normal_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in(bus.card_normal_irq_n),
      .sync_out(slot_req_n_sync)
   );

   slot_irq_sync #(
      .WIDTH(1)
   ) fast_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in(bus.card_fast_irq_n),
      .sync_out(fast_n_sync)
   );

   assign slot_req = ~slot_req_n_sync;

   // bus decode
   assign setup_cycle = psel && !penable;
   assign write_commit = psel && penable && pready && pwrite;
   assign addr_known = reg_hit(paddr, MASK_OFFSET) || reg_hit(paddr, STATUS_OFFSET);

   // phase tracker; pready is raised for exactly one access cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         phase_reg <= apb_idle;
      end
      else
      begin
         unique case (phase_reg)
            apb_idle:
            begin
               if (setup_cycle)
               begin
                  phase_reg <= apb_access;
               end
            end
            apb_access:
            begin
               phase_reg <= apb_idle;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
      end
      else
      begin
         pready <= setup_cycle && (phase_reg == apb_idle);
      end
   end

   // unmapped addresses answer with an error and change nothing
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pslverr <= 1'b0;
      end
      else
      begin
         pslverr <= setup_cycle && (phase_reg == apb_idle) && !addr_known;
      end
   end

   // read data is fixed in the setup cycle so it can leave a flop
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= READ_ZERO;
      end
      else if (setup_cycle && !pwrite && reg_hit(paddr, STATUS_OFFSET))
      begin
         prdata <= {{(DATA_WIDTH-REG_WIDTH){1'b0}}, status_next};
      end
      else
      begin
         // mask is write-only and reads as zero
         prdata <= READ_ZERO;
      end
   end

   // only the four slot bits are stored; reserved bits cannot enable anything
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mask_reg <= MASK_RESET[SLOT_COUNT-1:0];
      end
      else if (write_commit && reg_hit(paddr, MASK_OFFSET))
      begin
         mask_reg <= pwdata[SLOT_COUNT-1:0];
      end
   end

   // status has no write path at all
   always_comb
   begin
      status_next = STATUS_RESET;
      status_next[SLOT_COUNT-1:0] = mask_reg & slot_req;
   end

   // host normal line follows the gated status, not the raw slot lines, so masking works
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         host_normal_irq_n <= 1'b1;
      end
      else
      begin
         host_normal_irq_n <= !any_set(status_next[SLOT_COUNT-1:0]);
      end
   end

   // fast requests are not maskable here
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         host_fast_irq_n <= 1'b1;
      end
      else
      begin
         host_fast_irq_n <= fast_n_sync;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         host_irq_status_b <= STATUS_RESET;
      end
      else
      begin
         host_irq_status_b <= STATUS_RESET;
         host_irq_status_b[HOST_IRQ_STATUS_B_BIT] <= any_set(status_next[SLOT_COUNT-1:0]);
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         host_fiq_status <= STATUS_RESET;
      end
      else
      begin
         host_fiq_status <= STATUS_RESET;
         host_fiq_status[HOST_FIQ_STATUS_BIT] <= !fast_n_sync;
      end
   end

endmodule

/* slot_irq_bus.sv */
`timescale 1ns/1ps
interface slot_irq_bus
(
   input wire logic pclk,
   input wire logic presetn
);
   import slot_irq_pkg::*;
   slot_vec_t normal_out;
   slot_vec_t normal_oe_n;
   slot_vec_t fast_out;
   slot_vec_t fast_oe_n;
   // per-slot level seen by the backplane; pulled high when nobody drives
   slot_vec_t card_normal_irq_n;
   logic card_fast_irq_n;
   always_comb
   begin
      for (int i = 0; i < SLOT_COUNT; i++)
      begin
         card_normal_irq_n[i] = normal_oe_n[i] | normal_out[i];
      end
   end
   // shared wired line: any card may pull it low
   assign card_fast_irq_n = &(fast_oe_n | fast_out);
   modport card
   (
      input pclk,
      input presetn,
      output normal_out,
      output normal_oe_n,
      output fast_out,
      output fast_oe_n
   );
   modport backplane
   (
      input pclk,
      input presetn,
      input card_normal_irq_n,
      input card_fast_irq_n
   );
endinterface

/* slot_irq_card_end.sv */
`timescale 1ns/1ps
module slot_irq_card_end
(
   slot_irq_bus.card bus,
   input wire logic [slot_irq_pkg::SLOT_COUNT-1:0] normal_req,
   input wire logic [slot_irq_pkg::SLOT_COUNT-1:0] fast_req,
   output logic [slot_irq_pkg::SLOT_COUNT-1:0] normal_status,
   output logic [slot_irq_pkg::SLOT_COUNT-1:0] fast_status
);
   import slot_irq_pkg::*;
   // open drain: only ever drive low, release otherwise
   always_ff @(posedge bus.pclk or negedge bus.presetn)
   begin
      if (!bus.presetn)
      begin
         bus.normal_out <= '0;
         bus.normal_oe_n <= '1;
      end
      else
      begin
         bus.normal_out <= '0;
         bus.normal_oe_n <= ~normal_req;
      end
   end
   always_ff @(posedge bus.pclk or negedge bus.presetn)
   begin
      if (!bus.presetn)
      begin
         bus.fast_out <= '0;
         bus.fast_oe_n <= '1;
      end
      else
      begin
         bus.fast_out <= '0;
         bus.fast_oe_n <= ~fast_req;
      end
   end
   // local status moves in the same edge as the pin, so it is high whenever pulled low
   always_ff @(posedge bus.pclk or negedge bus.presetn)
   begin
      if (!bus.presetn)
      begin
         normal_status <= '0;
         fast_status <= '0;
      end
      else
      begin
         normal_status <= normal_req;
         fast_status <= fast_req;
      end
   end
endmodule

/* slot_irq_pkg.sv */
package slot_irq_pkg;
   localparam int unsigned SLOT_COUNT = 4;
   localparam int unsigned ADDR_WIDTH = 12;
   localparam int unsigned DATA_WIDTH = 32;
   localparam int unsigned REG_WIDTH = 8;
   localparam int unsigned SYNC_STAGES = 2;
   localparam logic [ADDR_WIDTH-1:0] MASK_OFFSET = 12'h000;
   localparam logic [ADDR_WIDTH-1:0] STATUS_OFFSET = 12'h004;
   localparam logic [REG_WIDTH-1:0] MASK_RESET = 8'h00;
   localparam logic [REG_WIDTH-1:0] STATUS_RESET = 8'h00;
   localparam int unsigned HOST_IRQ_STATUS_B_BIT = 5;
   localparam int unsigned HOST_FIQ_STATUS_BIT = 6;
   localparam logic [DATA_WIDTH-1:0] READ_ZERO = 32'h0000_0000;
   typedef logic [SLOT_COUNT-1:0] slot_vec_t;
   typedef logic [REG_WIDTH-1:0] reg_byte_t;
   typedef enum logic [1:0] {
      apb_idle,
      apb_access
   } apb_phase_t;
endpackage

/* slot_irq_sync.sv */
`timescale 1ns/1ps
module slot_irq_sync
#(
   parameter int unsigned WIDTH = 1
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1_reg;
   // lines idle high, so reset to the idle level to avoid a false request
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         stage1_reg <= '1;
         sync_out <= '1;
      end
      else
      begin
         stage1_reg <= async_in;
         sync_out <= stage1_reg;
      end
   end
endmodule

/* tb.sv */
`timescale 1ns/1ps
module tb;
   import slot_irq_pkg::*;
   logic pclk = 0;
   logic presetn = 0;
   logic [ADDR_WIDTH-1:0] paddr = '0;
   logic psel = 0;
   logic penable = 0;
   logic pwrite = 0;
   logic [DATA_WIDTH-1:0] pwdata = '0;
   logic [DATA_WIDTH-1:0] prdata;
   logic pready;
   logic pslverr;
   logic host_normal_irq_n;
   logic host_fast_irq_n;
   reg_byte_t host_irq_status_b;
   reg_byte_t host_fiq_status;
   slot_vec_t normal_req = '0;
   slot_vec_t fast_req = '0;
   slot_vec_t normal_status;
   slot_vec_t fast_status;
   slot_vec_t e;
   logic [31:0] m;
   int fails = 0;
   int n_checks = 0;
   logic [32:0] expq[$];
   always #2.5 pclk = ~pclk;
   slot_irq_bus u_slot_irq_bus(.pclk(pclk), .presetn(presetn));
   slot_irq_card_end u_slot_irq_card_end(.bus(u_slot_irq_bus), .normal_req(normal_req),
      .fast_req(fast_req), .normal_status(normal_status), .fast_status(fast_status));
   slot_irq_backplane u_slot_irq_backplane(.pclk(pclk), .presetn(presetn), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .bus(u_slot_irq_bus),
      .host_normal_irq_n(host_normal_irq_n), .host_fast_irq_n(host_fast_irq_n),
      .host_irq_status_b(host_irq_status_b), .host_fiq_status(host_fiq_status));
   slot_irq_assertions u_slot_irq_assertions(.pclk(pclk), .presetn(presetn),
      .normal_out(u_slot_irq_bus.normal_out), .normal_oe_n(u_slot_irq_bus.normal_oe_n),
      .fast_out(u_slot_irq_bus.fast_out), .fast_oe_n(u_slot_irq_bus.fast_oe_n),
      .card_normal_irq_n(u_slot_irq_bus.card_normal_irq_n),
      .card_fast_irq_n(u_slot_irq_bus.card_fast_irq_n));
   task chk(input string name, input logic [32:0] seen, input logic [32:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
         fails++;
      end
   endtask
   task conclude;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // exp holds {pslverr, read data}; writes expect zero data
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] exp);
      int k;
      k = 0;
      expq.push_back(exp);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         k++;
      end
      while (pready !== 1'b1 && k < 20);
      if (pready !== 1'b1)
      begin
         fails++;
         conclude();
      end
      psel <= 1'b0;
      penable <= 1'b0;
      // one idle edge so back-to-back calls never drive psel twice in one step
      @(posedge pclk);
   endtask
   // design outputs land by nonblocking update, so old values are seen here
   always @(posedge pclk)
   begin
      if (psel && penable && pready === 1'b1)
         chk("apb", {pslverr, pwrite ? READ_ZERO : prdata}, expq.size() ? expq.pop_front() : 'x);
   end
   initial
   begin
      void'($urandom(32'h08a4));
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk("host_n", host_normal_irq_n, 1'b1);
      apb(1'b0, STATUS_OFFSET, '0, {1'b0, READ_ZERO});
      apb(1'b0, MASK_OFFSET, '0, {1'b0, READ_ZERO});
      apb(1'b1, 12'h008, '0, {1'b1, READ_ZERO});
      $display("test reset and decode done");
      for (int t = 0; t < 16; t++)
      begin
         m = (t < 4) ? (32'hffff_ff00 | (32'h1 << t)) : ($urandom & 32'hffff_ff0f);
         apb(1'b1, MASK_OFFSET, m, '0);
         normal_req <= 4'($urandom);
         fast_req <= 4'($urandom);
         repeat (6) @(posedge pclk);
         e = normal_req & m[3:0];
         chk("card_normal", normal_status, normal_req);
         chk("card_fast", fast_status, fast_req);
         chk("host_n", host_normal_irq_n, ~|e);
         chk("status_b", host_irq_status_b, {2'b00, |e, 5'b0});
         chk("host_f", host_fast_irq_n, ~|fast_req);
         chk("fiq", host_fiq_status, {1'b0, |fast_req, 6'b0});
         apb(1'b1, STATUS_OFFSET, 32'hffff_ffff, '0);
         apb(1'b0, STATUS_OFFSET, '0, {1'b0, 28'h0, e});
      end
      $display("test mask and status done");
      @(posedge pclk);
      chk("queue", expq.size(), 0);
      conclude();
   end
endmodule
